// ===== rtl/sdx_status_mode.sv
// Status and mode registers of the converter behind its three-wire serial port.
//
// Operation
// - An eight-bit read-only status register is read by a read command with register select code zero.
// - The status register is shifted out most significant bit first, ending with bit zero.
// - Ready is cleared when a result is stored and set after a data read, before an update and at power-down.
// - The error flag is written with ready, set for a clamped result and cleared by a mode write.
// - Status bits five and four always read as zero.
// - Status bits two to zero report the channel currently being converted.
// - End of conversion also shows on the combined data-out and ready pin.
// - A sixteen-bit mode register at select code one shifts most significant bit first and resets to 000a.
// - Every mode write resets the modulator and filter and sets the ready flag.
// - Mode bits fifteen to thirteen select the operating mode.
// - Mode bits seven to six select internal clock, internal clock on the pin, or external clock.
// - With both clock bits set the external pin clock is divided by two.
// - Mode bits three to zero select the filter update rate.
// - A command starts only on a zero first bit; leading ones are ignored.
// - The second command bit chooses read when one and write when zero.
`include "sdx_consts.svh"
`timescale 1ns/1ps
module sdx_status_mode
  import sdx_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Serial port
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout_rdy_n,
  output logic o_dout_oe,
  // Converter core events
  input wire sdx_core_events_t i_core,
  // Clock sources and clock pin
  input wire logic i_int_clk,
  input wire logic i_clk_pin_in,
  output logic o_clk_pin_out,
  output logic o_clk_pin_oe,
  output logic o_conv_tick,
  // Mode fields, filter reset and ready flag
  output logic [2:0] o_operating_mode_select,
  output logic [1:0] o_clock_source_select,
  output logic [3:0] o_update_rate_select,
  output logic o_filter_reset,
  output logic o_ready_n
);
  function automatic sdx_status_t pack_status(input logic rdy, input logic err, input logic [2:0] chan);
    sdx_status_t s;
    s.not_ready = rdy;
    s.clamp_error = err;
    s.zero_bits = 2'b00;
    s.variant_bit = `SDX_SR3_VALUE;
    s.active_channel_code = chan;
    return s;
  endfunction

  sdx_state_t state_reg;
  sdx_state_t state_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [6:0] cmd_sr_reg;
  logic [15:0] rx_sr_reg;
  logic [15:0] tx_sr_reg;
  logic [15:0] mode_reg;
  logic [4:0] last_reg;
  logic rdy_reg;
  logic err_reg;
  logic dout_reg;
  logic dout_oe_reg;
  logic filter_reset_reg;
  logic sclk_rise;
  logic sclk_fall;

  sdx_sclk_edge u_edge (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_sclk(i_sclk),
    .o_rise(sclk_rise),
    .o_fall(sclk_fall)
  );

  sdx_clock_source u_clk (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clock_source_select(mode_reg[`SDX_MR_CLK_HI:`SDX_MR_CLK_LO]),
    .i_int_clk(i_int_clk),
    .i_clk_pin_in(i_clk_pin_in),
    .o_conv_tick(o_conv_tick),
    .o_clk_pin_out(o_clk_pin_out),
    .o_clk_pin_oe(o_clk_pin_oe)
  );

  wire active = ~i_cs_n;
  wire in_cmd = (state_reg == SDX_ST_CMD);
  wire in_read = (state_reg == SDX_ST_READ);
  wire in_write = (state_reg == SDX_ST_WRITE);
  wire cmd_hold = in_cmd & (cnt_reg == `SDX_CNT_ZERO) & i_din;
  wire [7:0] cmd_byte = {cmd_sr_reg, i_din};
  wire cmd_done = active & sclk_rise & in_cmd & (cnt_reg == `SDX_CMD_LAST);
  wire cmd_is_read = cmd_byte[`SDX_CR_RW];
  wire [2:0] cmd_rs = cmd_byte[`SDX_CR_RS_HI:`SDX_CR_RS_LO];
  wire rd_status = cmd_done & cmd_is_read & (cmd_rs == `SDX_RS_STATUS);
  wire rd_mode = cmd_done & cmd_is_read & (cmd_rs == `SDX_RS_MODE);
  wire wr_mode = cmd_done & ~cmd_is_read & (cmd_rs == `SDX_RS_MODE);
  wire data_end = active & sclk_rise & ~in_cmd & (cnt_reg == last_reg);
  wire mode_write = data_end & in_write;
  wire [15:0] mode_value = {rx_sr_reg[14:0], i_din};
  wire sdx_status_t status_now = pack_status(rdy_reg, err_reg, i_core.active_channel_code);
  wire rdy_set = i_core.data_read | i_core.pre_update | i_core.power_down_entry | mode_write;
  wire rdy_clr = i_core.result_write;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!active) begin
      state_next = SDX_ST_CMD;
      cnt_next = `SDX_CNT_ZERO;
    end else if (sclk_rise) begin
      if (cmd_hold) begin
        cnt_next = `SDX_CNT_ZERO;
      end else if (cmd_done) begin
        cnt_next = `SDX_CNT_ZERO;
        if (rd_status || rd_mode) begin
          state_next = SDX_ST_READ;
        end else if (wr_mode) begin
          state_next = SDX_ST_WRITE;
        end
      end else if (data_end) begin
        cnt_next = `SDX_CNT_ZERO;
        state_next = SDX_ST_CMD;
      end else begin
        cnt_next = cnt_reg + `SDX_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= SDX_ST_CMD;
      cnt_reg <= `SDX_CNT_ZERO;
      cmd_sr_reg <= 7'h00;
      rx_sr_reg <= 16'h0000;
      last_reg <= `SDX_STATUS_LAST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (active && sclk_rise && in_cmd && !cmd_hold) begin
        cmd_sr_reg <= cmd_byte[6:0];
      end
      if (active && sclk_rise && in_write) begin
        rx_sr_reg <= mode_value;
      end
      if (rd_status) begin
        last_reg <= `SDX_STATUS_LAST;
      end else if (rd_mode || wr_mode) begin
        last_reg <= `SDX_MODE_LAST;
      end
    end
  end

  // The transmit word is left aligned so bit fifteen is always the next bit out.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_sr_reg <= 16'h0000;
    end else if (rd_status) begin
      tx_sr_reg <= {status_now, 8'h00};
    end else if (rd_mode) begin
      tx_sr_reg <= mode_reg;
    end else if (active && sclk_fall && in_read) begin
      tx_sr_reg <= {tx_sr_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg <= `SDX_MODE_RESET;
      filter_reset_reg <= 1'b0;
    end else begin
      filter_reset_reg <= mode_write;
      if (mode_write) begin
        mode_reg <= mode_value;
      end
    end
  end

  // Set events win over a result store landing in the same cycle.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdy_reg <= 1'b1;
      err_reg <= 1'b0;
    end else begin
      if (rdy_set) begin
        rdy_reg <= 1'b1;
      end else if (rdy_clr) begin
        rdy_reg <= 1'b0;
      end
      if (rdy_clr && !rdy_set) begin
        err_reg <= i_core.result_clamped;
      end else if (mode_write) begin
        err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dout_reg <= 1'b1;
      dout_oe_reg <= 1'b0;
    end else begin
      dout_oe_reg <= active;
      if (in_read && active) begin
        if (sclk_fall) begin
          dout_reg <= tx_sr_reg[15];
        end
      end else begin
        dout_reg <= rdy_reg;
      end
    end
  end

  assign o_dout_rdy_n = dout_reg;
  assign o_dout_oe = dout_oe_reg;
  assign o_operating_mode_select = mode_reg[`SDX_MR_MODE_HI:`SDX_MR_MODE_LO];
  assign o_clock_source_select = mode_reg[`SDX_MR_CLK_HI:`SDX_MR_CLK_LO];
  assign o_update_rate_select = mode_reg[`SDX_MR_RATE_HI:`SDX_MR_RATE_LO];
  assign o_filter_reset = filter_reset_reg;
  assign o_ready_n = rdy_reg;

  chk_status_snapshot: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    rd_status |=> tx_sr_reg[15:8] == $past(status_now))
    else $error("status snapshot not loaded");
  chk_status_zero_bits: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    rd_status |=> tx_sr_reg[13:12] == 2'b00)
    else $error("status bits five and four not zero");
  chk_status_channel: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    rd_status |=> tx_sr_reg[10:8] == $past(i_core.active_channel_code))
    else $error("channel code wrong in status");
  chk_msb_first_out: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (in_read && active && sclk_fall) |=> o_dout_rdy_n == $past(tx_sr_reg[15]))
    else $error("serial output not msb first");
  chk_ready_set_wins: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    rdy_set |=> o_ready_n)
    else $error("ready flag not set");
  chk_ready_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (rdy_clr && !rdy_set) |=> !o_ready_n && (err_reg == $past(i_core.result_clamped)))
    else $error("ready or error not updated on result store");
  chk_mode_write_effect: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    mode_write |=> o_filter_reset && o_ready_n && !err_reg && mode_reg == $past(mode_value))
    else $error("mode write effects missing");
  chk_leading_ones_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (active && sclk_rise && cmd_hold) |=> cnt_reg == `SDX_CNT_ZERO && state_reg == SDX_ST_CMD)
    else $error("leading one advanced the command");
  chk_ready_on_pin: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (in_cmd && $past(in_cmd) && $stable(rdy_reg)) |-> o_dout_rdy_n == rdy_reg)
    else $error("ready not shown on data pin");
  chk_write_no_read: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (cmd_done && !cmd_is_read) |=> state_reg != SDX_ST_READ)
    else $error("write command started a read");

  // Checks on pin enables, transfer lengths and flag stability between events.
  chk_pin_enable_select: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_clk_pin_oe == ($past(o_clock_source_select) == `SDX_CLK_INT_OUT))
    else $error("clock pin enable does not follow the clock select");
  chk_data_pin_enable: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $past(i_arst_n) |-> o_dout_oe == $past(active))
    else $error("data pin enable does not follow chip select");
  chk_status_length: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    rd_status |=> last_reg == `SDX_STATUS_LAST && in_read)
    else $error("status read length wrong");
  chk_mode_length: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (rd_mode || wr_mode) |=> last_reg == `SDX_MODE_LAST && !in_cmd)
    else $error("mode transfer length wrong");
  chk_other_code_ignored: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (cmd_done && !rd_status && !rd_mode && !wr_mode) |=> in_cmd && cnt_reg == `SDX_CNT_ZERO)
    else $error("ignored command opened a data phase");
  chk_mode_stable_idle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !mode_write |=> $stable(mode_reg))
    else $error("mode register changed without a write");
  chk_error_only_events: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!rdy_clr && !mode_write) |=> $stable(err_reg))
    else $error("error flag changed without an event");
  chk_ready_only_events: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!rdy_set && !rdy_clr) |=> $stable(rdy_reg))
    else $error("ready flag changed without an event");
  chk_data_end_return: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    data_end |=> in_cmd && cnt_reg == `SDX_CNT_ZERO)
    else $error("data phase did not return to command");
  chk_tx_shift_left: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (in_read && active && sclk_fall) |=> tx_sr_reg == {$past(tx_sr_reg[14:0]), 1'b0})
    else $error("transmit word not shifted toward bit fifteen");
  chk_cmd_count_bound: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    in_cmd |-> cnt_reg <= `SDX_CMD_LAST)
    else $error("command bit counter out of range");

  cov_status_read: cover property (@(posedge i_clock) disable iff (!i_arst_n) rd_status);
  cov_mode_read: cover property (@(posedge i_clock) disable iff (!i_arst_n) rd_mode);
  cov_mode_write: cover property (@(posedge i_clock) disable iff (!i_arst_n) mode_write);
  cov_set_clear_clash: cover property (@(posedge i_clock) disable iff (!i_arst_n) rdy_set && rdy_clr);
  cov_leading_ones: cover property (@(posedge i_clock) disable iff (!i_arst_n) active && sclk_rise && cmd_hold);
endmodule

// ===== rtl/sdx_consts.svh
// Constants for the converter status and mode register block.
`ifndef SDX_CONSTS_SVH
`define SDX_CONSTS_SVH
`define SDX_RS_STATUS 3'h0
`define SDX_RS_MODE 3'h1
`define SDX_MODE_RESET 16'h000a
`define SDX_CMD_LAST 5'h07
`define SDX_STATUS_LAST 5'h07
`define SDX_MODE_LAST 5'h0f
`define SDX_CNT_ZERO 5'h00
`define SDX_CNT_ONE 5'h01
`define SDX_CR_RW 6
`define SDX_CR_RS_HI 5
`define SDX_CR_RS_LO 3
`define SDX_MR_MODE_HI 15
`define SDX_MR_MODE_LO 13
`define SDX_MR_CLK_HI 7
`define SDX_MR_CLK_LO 6
`define SDX_MR_RATE_HI 3
`define SDX_MR_RATE_LO 0
`define SDX_SR3_VALUE 1'b0
`define SDX_CLK_INT 2'h0
`define SDX_CLK_INT_OUT 2'h1
`define SDX_CLK_EXT 2'h2
`define SDX_CLK_EXT_DIV2 2'h3
`endif

// ===== rtl/sdx_pkg.sv
// Types shared by the converter status and mode register block.
package sdx_pkg;
  typedef enum logic [1:0] {
    SDX_ST_CMD = 2'b00,
    SDX_ST_READ = 2'b01,
    SDX_ST_WRITE = 2'b10
  } sdx_state_t;

  typedef struct packed {
    logic not_ready;
    logic clamp_error;
    logic [1:0] zero_bits;
    logic variant_bit;
    logic [2:0] active_channel_code;
  } sdx_status_t;

  typedef struct packed {
    logic result_write;
    logic result_clamped;
    logic data_read;
    logic pre_update;
    logic power_down_entry;
    logic [2:0] active_channel_code;
  } sdx_core_events_t;
endpackage

// ===== rtl/sdx_sclk_edge.sv
// Rising and falling edge detector for the host serial clock.
`timescale 1ns/1ps
module sdx_sclk_edge (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Serial clock level
  input wire logic i_sclk,
  // Edge pulses
  output logic o_rise,
  output logic o_fall
);
  logic sclk_prev_reg;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= i_sclk;
    end
  end

  assign o_rise = i_sclk & ~sclk_prev_reg;
  assign o_fall = ~i_sclk & sclk_prev_reg;
endmodule

// ===== rtl/sdx_clock_source.sv
// Converter clock source selection with pin output and divide by two.
`include "sdx_consts.svh"
`timescale 1ns/1ps
module sdx_clock_source (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Selection and clock levels
  input wire logic [1:0] i_clock_source_select,
  input wire logic i_int_clk,
  input wire logic i_clk_pin_in,
  // Converter clock and clock pin
  output logic o_conv_tick,
  output logic o_clk_pin_out,
  output logic o_clk_pin_oe
);
  logic int_prev_reg;
  logic ext_prev_reg;
  logic div_phase_reg;
  logic conv_tick_reg;
  logic pin_out_reg;
  logic pin_oe_reg;

  wire int_rise = i_int_clk & ~int_prev_reg;
  wire ext_rise = i_clk_pin_in & ~ext_prev_reg;
  wire sel_internal = ~i_clock_source_select[1];
  wire sel_div2 = (i_clock_source_select == `SDX_CLK_EXT_DIV2);
  wire tick_next = sel_internal ? int_rise : (sel_div2 ? (ext_rise & div_phase_reg) : ext_rise);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      div_phase_reg <= 1'b0;
      conv_tick_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      int_prev_reg <= i_int_clk;
      ext_prev_reg <= i_clk_pin_in;
      // With both clock bits set, only every second external edge makes a converter tick.
      if (ext_rise) begin
        div_phase_reg <= ~div_phase_reg;
      end
      conv_tick_reg <= tick_next;
      pin_out_reg <= i_int_clk;
      pin_oe_reg <= (i_clock_source_select == `SDX_CLK_INT_OUT);
    end
  end

  assign o_conv_tick = conv_tick_reg;
  assign o_clk_pin_out = pin_out_reg;
  assign o_clk_pin_oe = pin_oe_reg;
endmodule

// ===== test/sdx_host_model.sv
// Host serial master model that drives the converter's three-wire port.
`timescale 1ns/1ps
module sdx_host_model (
  // Clock
  input wire logic i_clock,
  // Transfer request
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [1:0] i_pre_ones,
  input wire logic [7:0] i_cmd,
  input wire logic [4:0] i_nbits,
  input wire logic [15:0] i_wdata,
  output logic o_busy,
  output logic [15:0] o_rdata,
  // Serial port
  input wire logic i_dout,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  int h;
  logic smp;
  task automatic bit_out(input logic b);
    o_sclk = 1'b0;
    o_din = b;
    repeat (h) @(negedge i_clock);
    smp = i_dout;
    o_sclk = 1'b1;
    repeat (h) @(negedge i_clock);
  endtask
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
    o_busy = 1'b0;
    o_rdata = 16'h0000;
    forever begin
      @(negedge i_clock);
      if (i_start) begin
        o_busy = 1'b1;
        o_rdata = 16'h0000;
        h = i_slow ? 7 : 4;
        o_cs_n = 1'b0;
        repeat (h) @(negedge i_clock);
        repeat (i_pre_ones) bit_out(1'b1);
        for (int k = 7; k >= 0; k--) bit_out(i_cmd[k]);
        for (int k = 0; k < i_nbits; k++) begin
          bit_out(i_cmd[6] ? 1'b0 : i_wdata[i_nbits - 1 - k]);
          o_rdata = {o_rdata[14:0], smp};
        end
        // Deselected data line toggles so a stale level is never trusted.
        o_cs_n = 1'b1;
        o_din = ~o_din;
        repeat (h) @(negedge i_clock);
        o_busy = 1'b0;
      end
    end
  end
endmodule

// ===== test/testbench.sv
// Self-checking testbench for the converter status and mode registers.
`timescale 1ns/1ps
module testbench;
  import sdx_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  sdx_core_events_t core = '0;
  logic int_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [1:0] pre = 2'h0;
  logic [7:0] cmd = 8'h00;
  logic [4:0] nbits = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic busy, cs_n, sclk, din, dout, dout_pin, dout_oe, pin_out, pin_oe, pin_lvl, tick, filt, ready_n;
  logic [2:0] op_sel;
  logic [1:0] clk_sel;
  logic [3:0] rate_sel;
  logic [31:0] seed = 32'h000006c6;
  logic [15:0] mode_m = 16'h000a;
  logic [15:0] wd;
  logic rdy_m = 1'b1;
  logic err_m = 1'b0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int nfilt = 0;
  int ntick = 0;
  int nint = 0;
  int next_n = 0;
  int nf, nt, ni, ne, expt;

  always #20 clock = ~clock;
  // The clock pin is driven by the device only while its enable is high.
  assign pin_lvl = pin_oe ? pin_out : ext_clk;
  // A released data pin shows the inverse level so a stale value is never trusted.
  assign dout_pin = dout_oe ? dout : ~dout;
  always @(negedge clock) begin
    cyc++;
    if (cyc % 10 == 0) int_clk <= ~int_clk;
    if (cyc % 7 == 0) ext_clk <= ~ext_clk;
  end
  always @(negedge clock) begin
    if (filt === 1'b1) nfilt++;
    if (tick === 1'b1) ntick++;
  end
  always @(posedge int_clk) nint++;
  always @(posedge ext_clk) next_n++;

  sdx_status_mode dut_u (.i_clock(clock), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .o_dout_rdy_n(dout), .o_dout_oe(dout_oe), .i_core(core), .i_int_clk(int_clk), .i_clk_pin_in(pin_lvl),
    .o_clk_pin_out(pin_out), .o_clk_pin_oe(pin_oe), .o_conv_tick(tick), .o_operating_mode_select(op_sel),
    .o_clock_source_select(clk_sel), .o_update_rate_select(rate_sel), .o_filter_reset(filt), .o_ready_n(ready_n));
  sdx_host_model host_u (.i_clock(clock), .i_start(start), .i_slow(slow), .i_pre_ones(pre), .i_cmd(cmd),
    .i_nbits(nbits), .i_wdata(wdata), .o_busy(busy), .o_rdata(rdata), .i_dout(dout_pin), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_din(din));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_near(input string what, input int exp, input int got);
    compares++;
    if (got < exp - 1 || got > exp + 1) begin
      err_total++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic [1:0] p, input logic [7:0] c, input logic [4:0] nb, input logic [15:0] d);
    int n;
    n = 0;
    pre <= p;
    cmd <= c;
    nbits <= nb;
    wdata <= d;
    slow <= ~slow;
    start <= 1'b1;
    @(negedge clock);
    start <= 1'b0;
    @(negedge clock);
    while (busy === 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 5000) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic pulse(input logic rw, input logic cl, input logic dr, input logic pu, input logic pd);
    core.result_write <= rw;
    core.result_clamped <= cl;
    core.data_read <= dr;
    core.pre_update <= pu;
    core.power_down_entry <= pd;
    if (dr | pu | pd) rdy_m = 1'b1;
    else if (rw) begin
      rdy_m = 1'b0;
      err_m = cl;
    end
    @(negedge clock);
    core[7:3] <= 5'h00;
    chk("ready flag", {15'h0000, rdy_m}, {15'h0000, ready_n});
  endtask
  task automatic rd_status();
    xfer(2'h0, 8'h40, 5'h08, 16'h0000);
    chk("status", {8'h00, rdy_m, err_m, 3'h0, core.active_channel_code}, rdata);
    chk("ready pin", {15'h0000, rdy_m}, {15'h0000, dout});
    chk("data pin enable", 16'h0000, {15'h0000, dout_oe});
  endtask
  task automatic rd_mode();
    xfer(2'h0, 8'h48, 5'h10, 16'h0000);
    chk("mode", mode_m, rdata);
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    conclude();
  end
  initial begin
    repeat (16) @(negedge clock);
    arst_n <= 1'b1;
    repeat (2) @(negedge clock);
    chk("mode fields", 16'h000a, {op_sel, 5'h00, clk_sel, 2'h0, rate_sel});
    rd_status();
    rd_mode();
    for (int i = 0; i < 3; i++) begin
      core.active_channel_code <= 3'(rnd() % 8);
      pulse(1'b1, 1'(rnd() % 2), 1'b0, 1'b0, 1'b0);
      rd_status();
      pulse(i == 2, 1'b0, i == 0, i == 1, i == 2);
      rd_status();
    end
    for (int s = 0; s < 4; s++) begin
      pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      nf = nfilt;
      wd = (16'(rnd()) & 16'he00f) | {8'h00, 2'(s), 6'h00};
      mode_m = wd;
      rdy_m = 1'b1;
      err_m = 1'b0;
      xfer(2'(s), 8'h08, 5'h10, wd);
      chk("filter reset pulses", 16'h0001, 16'(nfilt - nf));
      chk("ready after write", 16'h0001, {15'h0000, ready_n});
      chk("mode fields", wd, {op_sel, 5'h00, clk_sel, 2'h0, rate_sel});
      chk("clock pin enable", {15'h0000, s == 1}, {15'h0000, pin_oe});
      rd_status();
      rd_mode();
      nt = ntick;
      ni = nint;
      ne = next_n;
      repeat (420) @(negedge clock);
      chk("clock pin level", {15'h0000, int_clk}, {15'h0000, pin_out});
      expt = (s < 2) ? nint - ni : ((s == 2) ? next_n - ne : (next_n - ne) / 2);
      chk_near("converter ticks", expt, ntick - nt);
    end
    nf = nfilt;
    xfer(2'h0, 8'h08, 5'h08, 16'hffff);
    chk("aborted write", 16'h0000, 16'(nfilt - nf));
    rd_mode();
    xfer(2'h0, 8'h58, 5'h00, 16'h0000);
    xfer(2'h0, 8'h00, 5'h00, 16'h0000);
    rd_status();
    conclude();
  end
endmodule
